// *** dtc_consts.svh ***
// Notes on behaviour
// (R1) Each count is two bytes, low and high
// (R2) Each timer has its own mode select bits
// (R3) 13-bit: high byte, then low bits 4:0
// (R4) Software masks low byte bits 7:5
// (R5) Wrap 0x1FFF to zero sets overflow flag
// (R6) Counter select counts pin falling edges
// (R7) Else system clock or prescaled tick
// (R8) Count needs run and gate condition
// (R9) Gate polarity bit sets active level
// (R10) Run bit never clears the count
// (R11) Software loads count before run
// (R12) Second timer mirrors the first
// (R13) Interrupt enable gates overflow request
// (R14) Pins synchronised, one count per clock
// (R15) Flag held until write zero or vector
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// Register offsets
`define DTC_ADR_LOW_A 4'h0
`define DTC_ADR_HIGH_A 4'h1
`define DTC_ADR_LOW_B 4'h2
`define DTC_ADR_HIGH_B 4'h3
`define DTC_ADR_TCTL 4'h4
`define DTC_ADR_TMODE 4'h5
`define DTC_ADR_CKCTL 4'h6
`define DTC_ADR_EXTCFG 4'h7
`define DTC_ADR_IEN 4'h8
`define DTC_ADR_STS 4'h9
`define DTC_ADR_MSK 4'hA
// Field positions
`define DTC_TCTL_RUN_A 4
`define DTC_TCTL_OVF_A 5
`define DTC_TCTL_RUN_B 6
`define DTC_TCTL_OVF_B 7
`define DTC_TMODE_B_LSB 4
`define DTC_TMODE_CSEL 2
`define DTC_TMODE_GATE 3
`define DTC_CKCTL_SRC_A 3
`define DTC_CKCTL_SRC_B 4
`define DTC_EXTCFG_POL_A 3
`define DTC_EXTCFG_POL_B 7
`define DTC_IEN_A 1
`define DTC_IEN_B 3
// Reset values
`define DTC_RST_BYTE 8'h00
`define DTC_RST_COUNT 16'h0000
// Prescaler divisors selected by scale bits 1:0
`define DTC_DIV_S0 6'h0C
`define DTC_DIV_S1 6'h04
`define DTC_DIV_S2 6'h30
`define DTC_DIV_S3 6'h08
// Count limits
`define DTC_MAX13 13'h1FFF
`define DTC_MAX16 16'hFFFF
`endif

// *** dtc_pkg.sv ***
package dtc_pkg;
	// Timer operating modes, in mode select bit order
	typedef enum logic [1:0] {
		DTC_MODE_13,
		DTC_MODE_16,
		DTC_MODE_8R,
		DTC_MODE_SPLIT
	} dtc_mode_t;
endpackage

// *** dtc_sync.sv ***
`timescale 1ns/10ps
module dtc_sync #(
	parameter int W = 4
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_lvl,
	output logic [W-1:0] o_fall
);
	logic [W-1:0] s1_r, s2_r, s3_r; // Two-stage sync plus history
	logic [W-1:0] s1_nxt, s2_nxt, s3_nxt;
	// Shift chain; only s2 and s3 are looked at
	always_comb begin
		s1_nxt = i_d;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end
	// Falling edge from synchronised samples, one pulse per edge
	assign o_lvl = s2_r; // [R14]
	assign o_fall = s3_r & ~s2_r; // [R14]
endmodule

// *** dtc_timer.sv ***
`timescale 1ns/10ps
`include "dtc_consts.svh"
module dtc_timer import dtc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset,
	dtc_tmr_if.tmr tif
);
	logic [15:0] cnt_r, cnt_nxt; // Count, high and low bytes
	logic ovf_r, ovf_nxt; // Overflow pulse
	logic step; // Count enable this cycle
	logic [12:0] v13; // 13-bit view of the count
	logic [12:0] n13; // Incremented 13-bit value
	// Next count
	always_comb begin
		step = tif.run && (!tif.gate_en || tif.gate_act) // [R8]
			&& (tif.cnt_sel ? tif.pin_fall // [R6]
			: (tif.clk_src || tif.presc_tick)); // [R7]
		v13 = {cnt_r[15:8], cnt_r[4:0]}; // [R3]
		n13 = v13 + 13'h0001;
		cnt_nxt = cnt_r;
		ovf_nxt = 1'b0;
		if (tif.wr_lo) begin
			// Byte writes win over counting
			cnt_nxt[7:0] = tif.wdata; // [R1]
		end else if (tif.wr_hi) begin
			cnt_nxt[15:8] = tif.wdata; // [R1]
		end else if (step) begin
			unique case (tif.mode)
				DTC_MODE_13: begin
					// Bits 7:5 of the low byte are left alone
					cnt_nxt = {n13[12:5], cnt_r[7:5], n13[4:0]}; // [R3]
					ovf_nxt = (v13 == `DTC_MAX13); // [R5]
				end
				DTC_MODE_16, DTC_MODE_8R, DTC_MODE_SPLIT: begin
					// Modes in this block, all but 13-bit, count 16 bits
					cnt_nxt = cnt_r + 16'h0001;
					ovf_nxt = (cnt_r == `DTC_MAX16);
				end
			endcase
		end
	end
	// Registers; run bit changes never touch the count
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= `DTC_RST_COUNT;
			ovf_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt; // [R10]
			ovf_r <= ovf_nxt;
		end
	end
	assign tif.count = cnt_r;
	assign tif.ovf = ovf_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_hold_when_idle: assert property ( // [R8]
		!tif.run && !tif.wr_lo && !tif.wr_hi |=> $stable(cnt_r))
		else $error("count moved while stopped");
	a_wrap_sets_ovf: assert property ( // [R5]
		step && !tif.wr_lo && !tif.wr_hi && tif.mode == DTC_MODE_13
		&& v13 == `DTC_MAX13 |=> ovf_r && cnt_r[15:8] == 8'h00
		&& cnt_r[4:0] == 5'h00)
		else $error("13-bit wrap did not flag overflow");
	a_run_no_reload: assert property ( // [R10]
		$rose(tif.run) && !$past(tif.wr_lo) && !$past(tif.wr_hi)
		|-> cnt_r == $past(cnt_r))
		else $error("run bit altered the count");
	a_pin_edge_only: assert property ( // [R6]
		tif.cnt_sel && !tif.pin_fall && !tif.wr_lo && !tif.wr_hi
		|=> $stable(cnt_r))
		else $error("counted without pin edge");
endmodule

// *** dtc_tmr_if.sv ***
`timescale 1ns/10ps
interface dtc_tmr_if;
	import dtc_pkg::*;
	dtc_mode_t mode; // Operating mode
	logic cnt_sel; // Count pin edges
	logic gate_en; // Gate by external input
	logic gate_act; // Gate input at active level
	logic clk_src; // System clock when high
	logic presc_tick; // Prescaled tick pulse
	logic pin_fall; // Falling edge of count pin
	logic run; // Run bit
	logic wr_lo; // Low byte write
	logic wr_hi; // High byte write
	logic [7:0] wdata; // Byte write data
	logic [15:0] count; // Current count
	logic ovf; // Overflow pulse
	modport ctl(output mode, cnt_sel, gate_en, gate_act, clk_src,
		presc_tick, pin_fall, run, wr_lo, wr_hi, wdata,
		input count, ovf);
	modport tmr(input mode, cnt_sel, gate_en, gate_act, clk_src,
		presc_tick, pin_fall, run, wr_lo, wr_hi, wdata,
		output count, ovf);
endinterface

// *** dtc_top.sv ***
`timescale 1ns/10ps
`include "dtc_consts.svh"
module dtc_top import dtc_pkg::*; (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [3:0] i_addr, // Register offset
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	input wire logic i_count_pin_a, // Count input, timer a
	input wire logic i_count_pin_b, // Count input, timer b
	input wire logic i_gate_input_a, // Gate input, timer a
	input wire logic i_gate_input_b, // Gate input, timer b
	input wire logic i_vector_ack_a, // Processor vectors, timer a
	input wire logic i_vector_ack_b, // Processor vectors, timer b
	output logic o_timer_irq_a, // Overflow request, timer a
	output logic o_timer_irq_b, // Overflow request, timer b
	output logic o_irq // Summary interrupt
);
	// Software registers
	logic [7:0] timer_control_reg_r, timer_control_reg_nxt;
	logic [7:0] timer_mode_reg_r, timer_mode_reg_nxt;
	logic [7:0] clock_control_reg_r, clock_control_reg_nxt;
	logic [7:0] ext_irq_config_reg_r, ext_irq_config_reg_nxt;
	logic [7:0] interrupt_enable_reg_r, interrupt_enable_reg_nxt;
	logic [1:0] irq_status_r, irq_status_nxt; // Sticky events
	logic [1:0] irq_mask_r, irq_mask_nxt; // Event mask
	// Read path and outputs
	logic [7:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic tirq_a_r, tirq_a_nxt;
	logic tirq_b_r, tirq_b_nxt;
	// Prescaler
	logic [5:0] presc_r, presc_nxt;
	logic tick_r, tick_nxt;
	logic [5:0] div;
	// Synchronised pins: [0] pin a, [1] pin b, [2] gate a, [3] gate b
	logic [3:0] pin_lvl, pin_fall;
	// Per-timer views
	logic [1:0] ovf; // Overflow pulses
	logic [1:0] vec_ack; // Vector acknowledges
	logic [1:0] ovf_bit; // Flag positions in control
	logic [1:0] run_bit;
	logic [1:0] src_bit;
	logic [1:0] pol_bit;
	logic [1:0] ien_bit;
	logic [7:0] cnt_lo [2];
	logic [7:0] cnt_hi [2];

	dtc_tmr_if tif[2]();

	// Input synchroniser for count and gate pins
	dtc_sync #(.W(4)) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_d({i_gate_input_b, i_gate_input_a,
			i_count_pin_b, i_count_pin_a}),
		.o_lvl(pin_lvl),
		.o_fall(pin_fall)
	);

	assign vec_ack = {i_vector_ack_b, i_vector_ack_a};

	// Two identical timers, each with its own bits
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tmr
			localparam int ML = g * `DTC_TMODE_B_LSB;
			assign ovf_bit[g] = g ? timer_control_reg_r[`DTC_TCTL_OVF_B]
				: timer_control_reg_r[`DTC_TCTL_OVF_A];
			assign run_bit[g] = g ? timer_control_reg_r[`DTC_TCTL_RUN_B]
				: timer_control_reg_r[`DTC_TCTL_RUN_A];
			assign src_bit[g] = g ? clock_control_reg_r[`DTC_CKCTL_SRC_B]
				: clock_control_reg_r[`DTC_CKCTL_SRC_A];
			assign pol_bit[g] = g ? ext_irq_config_reg_r[`DTC_EXTCFG_POL_B]
				: ext_irq_config_reg_r[`DTC_EXTCFG_POL_A];
			assign ien_bit[g] = g ? interrupt_enable_reg_r[`DTC_IEN_B]
				: interrupt_enable_reg_r[`DTC_IEN_A];
			// Mode nibble per timer [R2] [R12]
			assign tif[g].mode = dtc_mode_t'(timer_mode_reg_r[ML +: 2]);
			assign tif[g].cnt_sel = timer_mode_reg_r[ML + `DTC_TMODE_CSEL];
			assign tif[g].gate_en = timer_mode_reg_r[ML + `DTC_TMODE_GATE];
			// Active level follows polarity bit [R9]
			assign tif[g].gate_act = (pin_lvl[2 + g] == pol_bit[g]);
			assign tif[g].clk_src = src_bit[g]; // [R7]
			assign tif[g].presc_tick = tick_r; // [R7]
			assign tif[g].pin_fall = pin_fall[g]; // [R6]
			assign tif[g].run = run_bit[g];
			assign tif[g].wr_lo = i_wr && (i_addr == 4'(2 * g)); // [R1]
			assign tif[g].wr_hi = i_wr && (i_addr == 4'(2 * g + 1));
			assign tif[g].wdata = i_wdata;
			assign ovf[g] = tif[g].ovf;
			assign cnt_lo[g] = tif[g].count[7:0];
			assign cnt_hi[g] = tif[g].count[15:8];
			dtc_timer u_tmr (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.tif(tif[g])
			);
		end
	endgenerate

	// Prescaler divisor from scale bits
	always_comb begin
		unique case (clock_control_reg_r[1:0])
			2'h0: div = `DTC_DIV_S0;
			2'h1: div = `DTC_DIV_S1;
			2'h2: div = `DTC_DIV_S2;
			2'h3: div = `DTC_DIV_S3;
		endcase
	end

	// Prescaler next state: one tick every div clocks
	always_comb begin
		tick_nxt = (presc_r >= div - 6'h01);
		presc_nxt = tick_nxt ? 6'h00 : presc_r + 6'h01;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			presc_r <= 6'h00;
			tick_r <= 1'b0;
		end else begin
			presc_r <= presc_nxt;
			tick_r <= tick_nxt;
		end
	end

	// Register writes, flags and read-clear status
	always_comb begin
		timer_control_reg_nxt = timer_control_reg_r;
		timer_mode_reg_nxt = timer_mode_reg_r;
		clock_control_reg_nxt = clock_control_reg_r;
		ext_irq_config_reg_nxt = ext_irq_config_reg_r;
		interrupt_enable_reg_nxt = interrupt_enable_reg_r;
		irq_mask_nxt = irq_mask_r;
		irq_status_nxt = irq_status_r;
		if (i_wr) begin
			unique case (i_addr)
				`DTC_ADR_TCTL: timer_control_reg_nxt = i_wdata;
				`DTC_ADR_TMODE: timer_mode_reg_nxt = i_wdata;
				`DTC_ADR_CKCTL: clock_control_reg_nxt = i_wdata;
				`DTC_ADR_EXTCFG: ext_irq_config_reg_nxt = i_wdata;
				`DTC_ADR_IEN: interrupt_enable_reg_nxt = i_wdata;
				`DTC_ADR_MSK: irq_mask_nxt = i_wdata[1:0];
				default: begin
				end
			endcase
		end
		// Vector clears a flag; a new overflow wins [R15]
		if (vec_ack[0])
			timer_control_reg_nxt[`DTC_TCTL_OVF_A] = 1'b0;
		if (vec_ack[1])
			timer_control_reg_nxt[`DTC_TCTL_OVF_B] = 1'b0;
		if (ovf[0])
			timer_control_reg_nxt[`DTC_TCTL_OVF_A] = 1'b1; // [R5]
		if (ovf[1])
			timer_control_reg_nxt[`DTC_TCTL_OVF_B] = 1'b1; // [R12]
		// Status read clears; set wins over clear
		if (i_rd && i_addr == `DTC_ADR_STS)
			irq_status_nxt = 2'h0;
		irq_status_nxt = irq_status_nxt | ovf;
	end

	// Read data, requests and summary interrupt
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				`DTC_ADR_LOW_A: rdata_nxt = cnt_lo[0]; // [R1]
				`DTC_ADR_HIGH_A: rdata_nxt = cnt_hi[0];
				`DTC_ADR_LOW_B: rdata_nxt = cnt_lo[1];
				`DTC_ADR_HIGH_B: rdata_nxt = cnt_hi[1];
				`DTC_ADR_TCTL: rdata_nxt = timer_control_reg_r;
				`DTC_ADR_TMODE: rdata_nxt = timer_mode_reg_r;
				`DTC_ADR_CKCTL: rdata_nxt = clock_control_reg_r;
				`DTC_ADR_EXTCFG: rdata_nxt = ext_irq_config_reg_r;
				`DTC_ADR_IEN: rdata_nxt = interrupt_enable_reg_r;
				`DTC_ADR_STS: rdata_nxt = {6'h00, irq_status_r};
				`DTC_ADR_MSK: rdata_nxt = {6'h00, irq_mask_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
		// Flag forwarded only when enabled [R13]
		tirq_a_nxt = ovf_bit[0] && ien_bit[0];
		tirq_b_nxt = ovf_bit[1] && ien_bit[1];
		irq_nxt = |(irq_status_r & irq_mask_r);
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			timer_control_reg_r <= `DTC_RST_BYTE;
			timer_mode_reg_r <= `DTC_RST_BYTE;
			clock_control_reg_r <= `DTC_RST_BYTE;
			ext_irq_config_reg_r <= `DTC_RST_BYTE;
			interrupt_enable_reg_r <= `DTC_RST_BYTE;
			irq_status_r <= 2'h0;
			irq_mask_r <= 2'h0;
			rdata_r <= `DTC_RST_BYTE;
			tirq_a_r <= 1'b0;
			tirq_b_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			timer_control_reg_r <= timer_control_reg_nxt;
			timer_mode_reg_r <= timer_mode_reg_nxt;
			clock_control_reg_r <= clock_control_reg_nxt;
			ext_irq_config_reg_r <= ext_irq_config_reg_nxt;
			interrupt_enable_reg_r <= interrupt_enable_reg_nxt;
			irq_status_r <= irq_status_nxt;
			irq_mask_r <= irq_mask_nxt;
			rdata_r <= rdata_nxt;
			tirq_a_r <= tirq_a_nxt;
			tirq_b_r <= tirq_b_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_timer_irq_a = tirq_a_r;
	assign o_timer_irq_b = tirq_b_r;
	assign o_irq = irq_r;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_ovf_sets_flag: assert property ( // [R5]
		ovf[0] |=> timer_control_reg_r[`DTC_TCTL_OVF_A])
		else $error("overflow did not set flag a");
	a_flag_sticky: assert property ( // [R15]
		ovf_bit[1] && !vec_ack[1] && !(i_wr && i_addr == `DTC_ADR_TCTL)
		|=> ovf_bit[1])
		else $error("flag b dropped without clear");
	a_irq_gated_en: assert property ( // [R13]
		##1 o_timer_irq_a == $past(ovf_bit[0] && ien_bit[0]))
		else $error("timer request not gated by enable");
	a_status_rdclr: assert property ( // [R5]
		i_rd && i_addr == `DTC_ADR_STS && ovf == 2'h0
		|=> irq_status_r == 2'h0 ##1 !o_irq)
		else $error("status read did not clear");
	// Second timer flag follows its own overflow pulse
	a_flag_b_set: assert property ( // [R12]
		ovf[1] |=> timer_control_reg_r[`DTC_TCTL_OVF_B])
		else $error("overflow did not set flag b");
	// Flag a holds until a vector or a control write
	a_flag_a_sticky: assert property ( // [R15]
		ovf_bit[0] && !vec_ack[0] && !(i_wr && i_addr == `DTC_ADR_TCTL)
		|=> ovf_bit[0])
		else $error("flag a dropped without clear");
	// Vectoring clears the flag when no new overflow arrives
	a_vector_clears: assert property ( // [R15]
		vec_ack[0] && !ovf[0] && !(i_wr && i_addr == `DTC_ADR_TCTL)
		|=> !ovf_bit[0])
		else $error("vector did not clear flag a");
	// Second request gated by its own enable bit
	a_irq_b_gated: assert property ( // [R13]
		##1 o_timer_irq_b == $past(ovf_bit[1] && ien_bit[1]))
		else $error("timer b request not gated by enable");
	// Overflow always lands in the sticky status
	a_status_sets: assert property ( // [R5]
		ovf[0] |=> irq_status_r[0])
		else $error("overflow did not set status a");
	// Summary line follows masked status one cycle late
	a_summary_irq: assert property ( // [R5]
		##1 o_irq == $past(|(irq_status_r & irq_mask_r)))
		else $error("summary interrupt wrong");
	// Read data stays zero outside the answer cycle
	a_rdata_idle: assert property ( // [R1]
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data without read strobe");
	// Prescaler tick lasts a single clock
	a_tick_single: assert property ( // [R7]
		tick_r |=> !tick_r)
		else $error("prescaler tick too long");
endmodule

// *** test_dual_thirteen_bit_counter_timer.sv ***
`timescale 1ns/10ps
`include "dtc_consts.svh"
module test_dual_thirteen_bit_counter_timer;
	logic i_clk; // Bench clock
	logic i_reset; // Async reset
	logic [3:0] i_addr; // Register offset
	logic [7:0] i_wdata; // Write data
	logic i_wr; // Write strobe
	logic i_rd; // Read strobe
	logic [7:0] o_rdata; // Read data
	logic [1:0] pin; // Count pins, b then a
	logic [1:0] gate; // Gate pins
	logic [1:0] ack; // Vector acknowledges
	logic [1:0] tirq; // Per timer requests
	logic o_irq; // Summary interrupt
	int n_fail; // Mismatch counter
	int check_count; // Comparison counter
	int cycles; // Timeout counter
	logic [15:0] rnd; // Random state
	int dv[4]; // Prescaler divisors

	dtc_top dut_u (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_count_pin_a(pin[0]),
		.i_count_pin_b(pin[1]),
		.i_gate_input_a(gate[0]),
		.i_gate_input_b(gate[1]),
		.i_vector_ack_a(ack[0]),
		.i_vector_ack_b(ack[1]),
		.o_timer_irq_a(tirq[0]),
		.o_timer_irq_b(tirq[1]),
		.o_irq(o_irq)
	);

	// Free running clock, 5 ns period
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// Sixteen bit shift register for random values
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Verdict and end of run
	task automatic conclude;
		$display("Checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compare one byte against the model
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One cycle write, then one idle cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	// One cycle read, data taken in the following cycle
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp,
		input logic [7:0] m);
		logic [7:0] v;
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		chk(v & m, exp);
		@(posedge i_clk);
	endtask

	// Load a 13-bit value into a timer
	task automatic load(input int t, input logic [12:0] v);
		wr(4'(2 * t), {3'b000, v[4:0]});
		wr(4'(2 * t + 1), v[12:5]);
	endtask

	// Check a 13-bit count, upper low bits ignored
	task automatic cnt_chk(input int t, input logic [12:0] exp);
		rdc(4'(2 * t), {3'b000, exp[4:0]}, 8'h1F);
		rdc(4'(2 * t + 1), exp[12:5], 8'hFF);
	endtask

	// Start with one write, stop with another k steps later
	task automatic span(input logic [3:0] sa, input logic [7:0] sd,
		input logic [3:0] pa, input logic [7:0] pd, input int k);
		wr(sa, sd);
		repeat (k - 2) @(posedge i_clk);
		wr(pa, pd);
	endtask

	// Hang guard
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		int i;
		int t;
		int n;
		int ex;
		logic g;
		logic [12:0] st;
		i_reset = 1'b1;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		pin = 2'b11;
		gate = 2'b00;
		ack = 2'b00;
		n_fail = 0;
		check_count = 0;
		cycles = 0;
		rnd = 16'd17438;
		dv = '{`DTC_DIV_S0, `DTC_DIV_S1, `DTC_DIV_S2, `DTC_DIV_S3};
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		// Every offset reads zero after reset, unmapped ones too
		for (i = 0; i < 16; i++) begin
			rdc(4'(i), 8'h00, 8'hFF);
		end
		// Status is read only
		wr(`DTC_ADR_STS, 8'hFF);
		rdc(`DTC_ADR_STS, 8'h00, 8'hFF);
		// Gate enable, polarity and level on both timers
		wr(`DTC_ADR_CKCTL, 8'h18);
		for (i = 0; i < 16; i++) begin
			t = i / 8;
			g = i[2];
			wr(`DTC_ADR_TMODE, 8'({4'h0, g, 3'b000} << (4 * t)));
			wr(`DTC_ADR_EXTCFG, 8'({4'h0, i[1], 3'b000} << (4 * t)));
			gate[t] <= i[0];
			rnd = lfsr_next(rnd);
			st = {1'b0, rnd[11:0]}; // No wrap, so status stays clear
			load(t, st);
			span(`DTC_ADR_TCTL, 8'h10 << (2 * t), `DTC_ADR_TCTL, 8'h00, 10);
			ex = (!g || i[0] == i[1]) ? st + 10 : st;
			cnt_chk(t, 13'(ex));
		end
		// Prescaled source, window a multiple of every divisor
		wr(`DTC_ADR_TMODE, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(`DTC_ADR_CKCTL, 8'(i));
			load(0, 13'h0000);
			span(`DTC_ADR_TCTL, 8'h10, `DTC_ADR_TCTL, 8'h00, 96);
			cnt_chk(0, 13'(96 / dv[i]));
		end
		// Pin edge counting, system clock left selected as a trap
		wr(`DTC_ADR_CKCTL, 8'h18);
		for (t = 0; t < 2; t++) begin
			wr(`DTC_ADR_TMODE, 8'h04 << (4 * t));
			load(t, 13'h0000);
			wr(`DTC_ADR_TCTL, 8'h10 << (2 * t));
			rnd = lfsr_next(rnd);
			n = rnd % 8 + 1;
			repeat (n) begin
				pin[t] <= 1'b0;
				repeat (2) @(posedge i_clk);
				pin[t] <= 1'b1;
				repeat (2) @(posedge i_clk);
			end
			repeat (6) @(posedge i_clk);
			wr(`DTC_ADR_TCTL, 8'h00);
			cnt_chk(t, 13'(n));
		end
		rdc(`DTC_ADR_STS, 8'h00, 8'hFF);
		// Wrap, flag, request with and without enable
		for (t = 0; t < 2; t++) begin
			g = (t == 0);
			wr(`DTC_ADR_CKCTL, 8'h08 << t);
			wr(`DTC_ADR_IEN, 8'({6'h00, g, 1'b0} << (2 * t)));
			wr(`DTC_ADR_MSK, 8'({7'h00, g} << t));
			load(t, 13'h1FF0);
			span(`DTC_ADR_TCTL, 8'h10 << (2 * t),
				`DTC_ADR_TMODE, 8'h04 << (4 * t), 20);
			cnt_chk(t, 13'h0004);
			rdc(`DTC_ADR_TCTL, 8'h30 << (2 * t), 8'hFF);
			chk({7'b0, tirq[t]}, {7'b0, g});
			chk({7'b0, o_irq}, {7'b0, g});
			rdc(`DTC_ADR_STS, 8'(1 << t), 8'hFF);
			rdc(`DTC_ADR_STS, 8'h00, 8'hFF);
			repeat (2) @(posedge i_clk);
			chk({7'b0, o_irq}, 8'h00);
			chk({7'b0, tirq[t]}, {7'b0, g});
			// Timer a cleared by vectoring, timer b by writing zero
			if (g) begin
				ack[t] <= 1'b1;
				@(posedge i_clk);
				ack[t] <= 1'b0;
				@(posedge i_clk);
			end else begin
				wr(`DTC_ADR_TCTL, 8'h40);
			end
			rdc(`DTC_ADR_TCTL, 8'h10 << (2 * t), 8'hFF);
			repeat (2) @(posedge i_clk);
			chk({7'b0, tirq[t]}, 8'h00);
			wr(`DTC_ADR_TCTL, 8'h00);
		end
		// Full 16-bit count on timer a, carry out of the low byte
		wr(`DTC_ADR_TMODE, 8'h01);
		wr(`DTC_ADR_CKCTL, 8'h08);
		wr(`DTC_ADR_LOW_A, 8'hFE);
		wr(`DTC_ADR_HIGH_A, 8'h00);
		span(`DTC_ADR_TCTL, 8'h10, `DTC_ADR_TCTL, 8'h00, 5);
		rdc(`DTC_ADR_LOW_A, 8'h03, 8'hFF);
		rdc(`DTC_ADR_HIGH_A, 8'h01, 8'hFF);
		conclude();
	end
endmodule
